// ===== src/aitp_consts.svh
/*
 Constants for the ASCII input template parser: register offsets, field
 positions, reset values and timing counts. Included by bare name.
*/
`ifndef AITP_CONSTS_SVH
`define AITP_CONSTS_SVH

`define AITP_CLK_HZ 20000000
`define AITP_GAP_MS 1000
`define AITP_GAP_CYC ((`AITP_CLK_HZ / 1000) * `AITP_GAP_MS)

`define AITP_REG_CTRL 4'h0
`define AITP_REG_TMPL 4'h1
`define AITP_REG_STAT 4'h2
`define AITP_REG_RDAT 4'h3

`define AITP_CTRL_EN_BIT 0
`define AITP_CTRL_TEN_BIT 1
`define AITP_CTRL_DST_LSB 2
`define AITP_CTRL_TERM_LSB 8

`define AITP_CTRL_RST 16'h0000
`define AITP_TMPL_RST 24'h000000

`endif

// ===== src/aitp_pkg.sv
/*
 Types for the ASCII input template parser.
 Assumes the constants header is compiled alongside.
*/
package aitp_pkg;
    typedef enum logic [1:0] {
        AITP_DST_KEYPAD = 2'h0,
        AITP_DST_TARE = 2'h1,
        AITP_DST_TARE_ID = 2'h2,
        AITP_DST_TARGET_ID = 2'h3
    } aitp_dst_t;

    typedef enum logic [2:0] {
        AITP_ST_IDLE = 3'b001,
        AITP_ST_RECV = 3'b010,
        AITP_ST_OUT = 3'b100
    } aitp_state_t;
endpackage

// ===== src/aitp_fifo_if.sv
/*
 Valid/ready byte channel between the parser and its input FIFO.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface aitp_fifo_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== src/aitp_fifo.sv
/*
 Small FIFO with valid/ready on both sides, storage in flip-flops.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module aitp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    aitp_fifo_if.src out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } aitp_fifo_st_t;
    aitp_fifo_st_t s_q, s_d;
    logic push, pop;

    assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
    assign out.valid = (s_q.cnt != '0);
    assign out.data = s_q.mem[s_q.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out.valid && out.ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_fifo_no_over: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule
`default_nettype wire

// ===== src/aitp_parser.sv
/*
 ASCII input template parser. Takes characters from a serial receiver,
 strips a leading count and, on a terminator, a trailing count, keeps up to a data length, and ends
 a string on a control character or after a one-second gap.
 Assumes the receiver delivers whole characters as one-cycle strobes
 synchronous to clk_i, and a plain register port from software.
*/
// The plain strobed port and the register addresses were decided locally.
// Overview of operation
// R1 - Skip the configured preamble count of characters at each string start.
// R2 - Keep up to data length characters after the preamble as payload.
// R3 - Remove postamble count of characters just before the terminator.
// R4 - End the string on the configured control character, or on no character if none.
// R5 - With no terminator configured, only the gap timeout ends a string.
// R6 - More than one second without a character terminates the string.
// R7 - On termination deliver the collected payload to the selected target.
// R8 - Tare or target identifier targets start a table lookup with the key.
// R9 - Sender keeps identical leading and trailing framing for every string.
// R10 - Fixed-length inputs should leave the trailing strip count at zero.
// R11 - Drop characters beyond the limit; pulse valid with payload length.
`timescale 1ns/100ps
`default_nettype none
`include "aitp_consts.svh"
module aitp_parser
    import aitp_pkg::*;
#(
    parameter int MAX_LEN = 16,
    parameter int FIFO_DEPTH = 4,
    parameter int GAP_CYCLES = `AITP_GAP_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic rx_ready_o,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic out_valid_o,
    output logic [8*MAX_LEN-1:0] out_data_o,
    output logic [7:0] out_len_o,
    output logic [1:0] out_dst_o,
    output logic lookup_tare_o,
    output logic lookup_target_o
);
    localparam int GW = $clog2(GAP_CYCLES + 1);

    typedef struct packed {
        aitp_state_t st;
        logic [15:0] ctrl;
        logic [23:0] tmpl;
        logic [7:0] pre_cnt;
        logic [7:0] len;
        logic [GW-1:0] gap;
        logic [MAX_LEN-1:0][7:0] buf_b;
        logic [31:0] rdata;
        logic out_valid;
        logic [8*MAX_LEN-1:0] out_data;
        logic [7:0] out_len;
        logic [1:0] out_dst;
        logic lk_tare;
        logic lk_target;
        logic [7:0] ovr;
        logic [15:0] strings;
    } aitp_st_t;

    aitp_st_t s_q, s_d;
    aitp_fifo_if #(.W(8)) ch ();
    logic in_ready;

    aitp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(in_ready),
        .in_data_i(rx_data_i),
        .out(ch)
    );

    // Only control characters may serve as terminator.
    function automatic logic is_ctl(input logic [7:0] c);
        return (c < 8'h20) || (c == 8'h7F);
    endfunction

    function automatic logic [7:0] lim(input logic [7:0] v);
        return (v > 8'(MAX_LEN)) ? 8'(MAX_LEN) : v;
    endfunction

    // Terminator seen in IDLE or RECV is latched so the tail strip uses it in OUT.
    logic term_seen_q;
    logic [7:0] pre_len, data_len, post_len, term_chr, kept_len;
    logic en, term_en, is_term;
    logic [1:0] dst;
    assign pre_len = s_q.tmpl[7:0];
    assign data_len = lim(s_q.tmpl[15:8]);
    assign post_len = s_q.tmpl[23:16];
    assign en = s_q.ctrl[`AITP_CTRL_EN_BIT];
    assign term_en = s_q.ctrl[`AITP_CTRL_TEN_BIT];
    assign dst = s_q.ctrl[`AITP_CTRL_DST_LSB +: 2];
    assign term_chr = s_q.ctrl[`AITP_CTRL_TERM_LSB +: 8];
    assign is_term = term_en && is_ctl(term_chr) && ch.data == term_chr; // R4 R5
    // Postamble applies only when the string ended on a terminator.
    // In OUT the FIFO head is already the next string, so the latched
    // terminator flag decides, not the character now at the head.
    assign kept_len = (term_seen_q && s_q.len > post_len) ?
        s_q.len - post_len : (term_seen_q ? 8'h00 : s_q.len); // R3
    // Characters stay queued while the parser is idle and disabled, or delivering; RECV takes them even when disabled.
    assign ch.ready = (s_q.st == AITP_ST_RECV) ||
        (s_q.st == AITP_ST_IDLE && en);

    always_comb begin
        s_d = s_q;
        s_d.out_valid = 1'b0;
        s_d.lk_tare = 1'b0;
        s_d.lk_target = 1'b0;
        s_d.rdata = 32'h00000000;
        if (wr_i) begin
            unique case (addr_i)
                `AITP_REG_CTRL: s_d.ctrl = wdata_i[15:0];
                `AITP_REG_TMPL: s_d.tmpl = wdata_i[23:0];
                default: ;
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                `AITP_REG_CTRL: s_d.rdata = {16'h0000, s_q.ctrl};
                `AITP_REG_TMPL: s_d.rdata = {8'h00, s_q.tmpl};
                `AITP_REG_STAT: s_d.rdata = {s_q.strings, s_q.ovr,
                    5'h00, s_q.st};
                `AITP_REG_RDAT: s_d.rdata = {24'h000000, s_q.out_len};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        unique case (s_q.st)
            AITP_ST_IDLE: begin
                s_d.pre_cnt = 8'h00;
                s_d.len = 8'h00;
                s_d.gap = '0;
                if (en && ch.valid) begin
                    s_d.st = AITP_ST_RECV;
                    if (is_term) begin
                        s_d.st = AITP_ST_OUT;
                    end else if (pre_len != 8'h00) begin
                        s_d.pre_cnt = 8'h01; // R1
                    end else begin
                        s_d.buf_b[0] = ch.data; // R2
                        s_d.len = 8'h01;
                    end
                end
            end
            AITP_ST_RECV: begin
                if (ch.valid) begin
                    s_d.gap = '0;
                    if (is_term) begin
                        s_d.st = AITP_ST_OUT; // R4
                    end else if (s_q.pre_cnt < pre_len) begin
                        s_d.pre_cnt = s_q.pre_cnt + 8'h01; // R1
                    end else if (s_q.len < data_len) begin
                        s_d.buf_b[s_q.len[$clog2(MAX_LEN)-1:0]] = ch.data;
                        s_d.len = s_q.len + 8'h01; // R2
                    end else if (s_q.ovr != 8'hFF) begin
                        s_d.ovr = s_q.ovr + 8'h01; // R11
                    end
                end else if (s_q.gap == GW'(GAP_CYCLES)) begin
                    s_d.st = AITP_ST_OUT; // R6
                end else begin
                    s_d.gap = s_q.gap + 1'b1; // R6
                end
            end
            AITP_ST_OUT: begin
                s_d.st = AITP_ST_IDLE;
                s_d.out_valid = 1'b1; // R7 R11
                s_d.out_len = kept_len;
                s_d.out_data = '0;
                for (int i = 0; i < MAX_LEN; i++) begin
                    if (8'(i) < kept_len) begin
                        s_d.out_data[8*i +: 8] = s_q.buf_b[i];
                    end
                end
                s_d.out_dst = dst;
                s_d.lk_tare = (dst == AITP_DST_TARE_ID); // R8
                s_d.lk_target = (dst == AITP_DST_TARGET_ID); // R8
                s_d.strings = s_q.strings + 16'h0001;
            end
            default: s_d.st = AITP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.st <= AITP_ST_IDLE;
            s_q.ctrl <= `AITP_CTRL_RST;
            s_q.tmpl <= `AITP_TMPL_RST;
            term_seen_q <= 1'b0;
            rx_ready_o <= 1'b0;
        end else begin
            s_q <= s_d;
            rx_ready_o <= in_ready;
            if (s_q.st != AITP_ST_OUT) begin
                term_seen_q <= ch.valid && is_term;
            end
        end
    end

    assign rdata_o = s_q.rdata;
    assign out_valid_o = s_q.out_valid;
    assign out_data_o = s_q.out_data;
    assign out_len_o = s_q.out_len;
    assign out_dst_o = s_q.out_dst;
    assign lookup_tare_o = s_q.lk_tare;
    assign lookup_target_o = s_q.lk_target;

    sequence gap_run;
        (s_q.st == AITP_ST_RECV) && !ch.valid && s_q.gap == GW'(GAP_CYCLES);
    endsequence
    sequence deliver;
        ##1 (s_q.st == AITP_ST_OUT) ##1 out_valid_o;
    endsequence

    a_gap_ends_string: assert property (@(posedge clk_i) disable iff
        (!resetn_i) gap_run |-> deliver) // R6
        else $error("gap timeout did not end string");
    a_term_ends_string: assert property (@(posedge clk_i) disable iff
        (!resetn_i) (s_q.st == AITP_ST_RECV && ch.valid && is_term)
        |-> ##2 out_valid_o) // R4
        else $error("terminator did not end string");
    a_len_bounded: assert property (@(posedge clk_i) disable iff
        (!resetn_i) out_valid_o |-> out_len_o <= data_len) // R2
        else $error("payload longer than data length");
    a_pre_skipped: assert property (@(posedge clk_i) disable iff
        (!resetn_i) (s_q.len != 8'h00) |-> s_q.pre_cnt == pre_len) // R1
        else $error("payload collected before preamble done");
    a_valid_pulse: assert property (@(posedge clk_i) disable iff
        (!resetn_i) out_valid_o |=> !out_valid_o) // R11
        else $error("valid longer than one cycle");
    a_lookup_dst: assert property (@(posedge clk_i) disable iff
        (!resetn_i) lookup_tare_o |-> out_valid_o &&
        out_dst_o == AITP_DST_TARE_ID) // R8
        else $error("tare lookup without matching delivery");
    a_no_term_timeout: assert property (@(posedge clk_i) disable iff
        (!resetn_i) (s_q.st == AITP_ST_RECV && !term_en && ch.valid)
        |=> s_q.st == AITP_ST_RECV) // R5
        else $error("string ended without terminator or gap");
    a_post_strip: assert property (@(posedge clk_i) disable iff
        (!resetn_i) (s_q.st == AITP_ST_OUT && term_seen_q &&
        s_q.len > post_len) |=> out_len_o == $past(s_q.len) - $past(post_len))
        // R3
        else $error("postamble not stripped");
    a_dst_kept: assert property (@(posedge clk_i) disable iff
        (!resetn_i) out_valid_o |-> out_dst_o == $past(dst)) // R7
        else $error("wrong destination delivered");
endmodule
`default_nettype wire

// ===== bench/aitp_sender.sv
/*
 Model of the serial character sender that feeds the parser.
 Assumes the caller enters send_str just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module aitp_sender (
    input wire logic clk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] data_o
);
    initial begin
        valid_o = 1'b0;
        data_o = 8'h00;
    end

    // Each string is sent whole with the framing the caller configured.
    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            valid_o <= 1'b1;
            data_o <= s[i];
            do @(posedge clk_i); while (ready_i !== 1'b1);
        end
        // An idle line must not keep showing the last character.
        valid_o <= 1'b0;
        data_o <= ~s[s.len()-1];
    endtask
endmodule
`default_nettype wire

// ===== bench/test_ascii_input_template_parser.sv
/*
 Self-checking bench for the ASCII input template parser.
 Assumes the package, FIFO, interface, parser and sender are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aitp_consts.svh"
module test_ascii_input_template_parser import aitp_pkg::*;;
    localparam int GAP = 50;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rx_valid_i;
    logic [7:0] rx_data_i;
    logic rx_ready_o;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic out_valid_o;
    logic [127:0] out_data_o;
    logic [7:0] out_len_o;
    logic [1:0] out_dst_o;
    logic lookup_tare_o;
    logic lookup_target_o;
    logic [127:0] got_data;
    logic [7:0] got_len;
    logic [1:0] got_dst;
    logic got_lt;
    logic got_lg;
    int mismatches = 0;
    int n_checks = 0;
    int n_deliv = 0;
    int cycles = 0;

    always #25 clk_i = ~clk_i;

    aitp_parser #(.MAX_LEN(16), .FIFO_DEPTH(4), .GAP_CYCLES(GAP)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .rx_valid_i(rx_valid_i),
        .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .out_valid_o(out_valid_o), .out_data_o(out_data_o),
        .out_len_o(out_len_o), .out_dst_o(out_dst_o),
        .lookup_tare_o(lookup_tare_o), .lookup_target_o(lookup_target_o)
    );

    aitp_sender snd (
        .clk_i(clk_i), .ready_i(rx_ready_o),
        .valid_o(rx_valid_i), .data_o(rx_data_i)
    );

    // Capture each delivery in the cycle its strobe stands.
    always @(posedge clk_i) begin
        if (out_valid_o === 1'b1) begin
            n_deliv <= n_deliv + 1;
            got_data <= out_data_o;
            got_len <= out_len_o;
            got_dst <= out_dst_o;
            got_lt <= lookup_tare_o;
            got_lg <= lookup_target_o;
        end
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, exp);
    endtask

    task automatic wait_deliv(input int n);
        int k;
        k = 0;
        while (n_deliv < n && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        if (n_deliv < n) begin
            mismatches++;
            $display("ERROR %0t no delivery", $time);
        end
        @(posedge clk_i);
        #1;
    endtask

    function automatic logic [127:0] pk(input string s);
        logic [127:0] v;
        v = '0;
        for (int i = 0; i < s.len(); i++) v[8*i +: 8] = s[i];
        return v;
    endfunction

    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        #1;
        rd(`AITP_REG_CTRL, 32'h0000_0000);
        rd(`AITP_REG_TMPL, 32'h0000_0000);
        rd(`AITP_REG_STAT, 32'h0000_0001);
        wr(4'h7, 32'hFFFF_FFFF);
        rd(4'h7, 32'h0000_0000);
        // Extra characters past the data length are dropped.
        wr(`AITP_REG_TMPL, 32'h0000_0502);
        wr(`AITP_REG_CTRL, 32'h0000_0D07);
        snd.send_str("\002P001.5 kg\015");
        wait_deliv(1);
        check(got_data, pk("001.5"));
        check(got_len, 8'h05);
        check(got_dst, AITP_DST_TARE);
        check({got_lt, got_lg}, 2'b00);
        // The same value obtained by stripping the tail instead.
        wr(`AITP_REG_TMPL, 32'h0003_0802);
        wr(`AITP_REG_CTRL, 32'h0000_0D0B);
        snd.send_str("\002P001.5 kg\015");
        wait_deliv(2);
        check(got_data, pk("001.5"));
        check(got_len, 8'h05);
        check(got_dst, AITP_DST_TARE_ID);
        check({got_lt, got_lg}, 2'b10);
        // Another control character ends it; the old one is now data.
        wr(`AITP_REG_TMPL, 32'h0000_0800);
        wr(`AITP_REG_CTRL, 32'h0000_0403);
        snd.send_str("1\0152\004");
        wait_deliv(3);
        check(got_data, pk("1\0152"));
        check(got_dst, AITP_DST_KEYPAD);
        // Fill the FIFO while disabled, then drain it and end on the gap.
        wr(`AITP_REG_TMPL, 32'h0003_0800);
        wr(`AITP_REG_CTRL, 32'h0000_000C);
        fork
            snd.send_str("WXYZ");
        join_none
        repeat (10) @(posedge clk_i);
        #1 check(rx_ready_o, 1'b0);
        wr(`AITP_REG_CTRL, 32'h0000_000D);
        repeat (GAP) @(posedge clk_i);
        #1 check(128'(n_deliv), 128'd3);
        wait_deliv(4);
        check(got_data, pk("WXYZ"));
        check(got_len, 8'h04);
        check(got_dst, AITP_DST_TARGET_ID);
        check({got_lt, got_lg}, 2'b01);
        rd(`AITP_REG_RDAT, 32'h0000_0004);
        rd(`AITP_REG_STAT, 32'h0004_0301);
        complete_run();
    end
endmodule
`default_nettype wire
